/* eapc_ext_pin_irq.sv */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module eapc_ext_pin_irq
    import eapc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                ext_irq0_pin,
    input  wire logic [NUM_PINS-1:0] change_watch_pins,
    input  wire logic                sleepActive,
    input  wire eapc_irq_t           vectorTaken,
    output eapc_irq_t                irqRequest,
    output logic                     wakeRequest
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (ADDR_W < IDX_W + 3) begin : g_bad_addr
        $error("ADDR_W too small for the register map");
    end

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rstPipe;
    logic       rstSyncN;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end

    assign rstSyncN = rstPipe[1];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  pcFlags;
    logic [7:0]  extFlag;
    logic [7:0]  extMask;
    logic [7:0]  statusReg;
    logic [7:0]  grpEnable;
    logic [7:0]  senseCtrl;
    logic [7:0]  mask0;
    logic [7:0]  mask1;
    logic [7:0]  mask2;
    logic [7:0]  mask3;
    logic        globalEn;
    eapc_sense_t senseMode;

    assign globalEn  = statusReg[GIE_BIT];
    assign senseMode = eapc_sense_t'(senseCtrl[1:0]);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic isMapped(input logic [7:0] idx);
        case (idx)
            IDX_PC_FLAGS, IDX_EXT_FLAG, IDX_EXT_MASK,
            IDX_STATUS, IDX_GRP_EN, IDX_SENSE,
            IDX_MASK0, IDX_MASK1, IDX_MASK2,
            IDX_MASK3: isMapped = 1'b1;
            default:   isMapped = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] addrIndex(input logic [ADDR_W-1:0] a);
        addrIndex = a[IDX_W+1:2];
    endfunction

    function automatic logic addrInRange(input logic [ADDR_W-1:0] a);
        addrInRange = (a[ADDR_W-1:IDX_W+2] == '0) && (a[1:0] == 2'b00);
    endfunction

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    logic              awHeld;
    logic              wHeld;
    logic [ADDR_W-1:0] wrAddr;
    logic [7:0]        wrData;
    logic              wrLane0;
    logic              doWrite;
    logic              wrOk;
    logic [7:0]        wrIdx;

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign doWrite       = awHeld && wHeld && !s_axi_bvalid;
    assign wrIdx         = addrIndex(wrAddr);
    assign wrOk          = addrInRange(wrAddr) && isMapped(wrIdx);

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            awHeld <= 1'b0;
            wrAddr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            wrAddr <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wHeld   <= 1'b0;
            wrData  <= 8'h00;
            wrLane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld   <= 1'b1;
            wrData  <= s_axi_wdata[7:0];
            wrLane0 <= s_axi_wstrb[0];
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // a write without byte lane 0 is answered but stores nothing
    logic       wrHit;
    logic [7:0] wrOnes;

    assign wrHit  = doWrite && wrOk && wrLane0;
    assign wrOnes = wrHit ? wrData : 8'h00;

    // ------------------------------------------------------------
    // plain read/write registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            extMask   <= REG_RESET;
            statusReg <= REG_RESET;
            grpEnable <= REG_RESET;
            senseCtrl <= REG_RESET;
            mask0     <= REG_RESET;
            mask1     <= REG_RESET;
            mask2     <= REG_RESET;
            mask3     <= REG_RESET;
        end else if (wrHit) begin
            case (wrIdx)
                IDX_EXT_MASK: extMask   <= wrData & WM_EXT;
                IDX_STATUS:   statusReg <= wrData & WM_STATUS;
                IDX_GRP_EN:   grpEnable <= wrData & WM_GRP_EN;
                IDX_SENSE:    senseCtrl <= wrData & WM_SENSE;
                IDX_MASK0:    mask0     <= wrData & WM_MASK0;
                IDX_MASK1:    mask1     <= wrData & WM_MASK1;
                IDX_MASK2:    mask2     <= wrData & WM_MASK2;
                IDX_MASK3:    mask3     <= wrData & WM_MASK3;
                default:      extMask   <= extMask;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // the pad value is taken whatever the pin direction
    logic [NUM_PINS:0] syncA;
    logic [NUM_PINS:0] syncB;
    logic [NUM_PINS:0] syncC;
    logic [NUM_PINS:0] stable;
    logic [NUM_PINS:0] nextStable;

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
        end else begin
            syncA <= {ext_irq0_pin, change_watch_pins};
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    // a bit moves only once the last two stages agree
    assign nextStable = (syncB & syncC) | (stable & (syncB | syncC));

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            stable <= '0;
        end else begin
            stable <= nextStable;
        end
    end

    // ------------------------------------------------------------
    // external line 0
    // ------------------------------------------------------------
    logic extGate;
    logic extLevel;
    logic extLevelQ;
    logic extRise;
    logic extFall;
    logic extEvent;
    logic extClear;

    // input buffer off in sleep while the line is masked
    assign extGate  = sleepActive && !extMask[0];
    assign extLevel = extGate ? 1'b0 : nextStable[NUM_PINS];

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            extLevelQ <= 1'b0;
        end else begin
            extLevelQ <= extLevel;
        end
    end

    assign extRise = extLevel && !extLevelQ;
    assign extFall = !extLevel && extLevelQ;

    always_comb begin
        case (senseMode)
            SENSE_ANY:  extEvent = extRise || extFall;
            SENSE_FALL: extEvent = extFall;
            SENSE_RISE: extEvent = extRise;
            default:    extEvent = 1'b0;
        endcase
    end

    assign extClear = wrOnes[0] && (wrIdx == IDX_EXT_FLAG);

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            extFlag <= REG_RESET;
        end else if (senseMode == SENSE_LOW) begin
            extFlag <= REG_RESET;
        end else if (extEvent) begin
            extFlag <= WM_EXT;
        end else if (extClear || vectorTaken.ext0) begin
            extFlag <= REG_RESET;
        end
    end

    // ------------------------------------------------------------
    // pin-change groups
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0]   pinEnable;
    logic [NUM_PINS-1:0]   pinChanged;
    logic [NUM_GROUPS-1:0] grpHit;
    logic [NUM_GROUPS-1:0] grpClear;

    // mask1 keeps only bit 3, so its low nibble lands on pins 11:8
    assign pinEnable = {mask3[3:0], mask2, 4'h0, mask1[3:0], 4'h0, mask0[3:0]};
    assign pinChanged = nextStable[NUM_PINS-1:0] ^ stable[NUM_PINS-1:0];

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
        // a masked-in pin only counts while its group is enabled
        assign grpHit[g]   = |(pinChanged & pinEnable & GRP_PINS[g]
                               & {NUM_PINS{grpEnable[g]}});
        assign grpClear[g] = (wrOnes[g] && (wrIdx == IDX_PC_FLAGS))
                             || vectorTaken.group[g];

        always_ff @(posedge core_clk or negedge rstSyncN) begin
            if (!rstSyncN) begin
                pcFlags[g] <= 1'b0;
            end else if (grpHit[g]) begin
                pcFlags[g] <= 1'b1;
            end else if (grpClear[g]) begin
                pcFlags[g] <= 1'b0;
            end
        end
    end

    assign pcFlags[7:NUM_GROUPS] = '0;

    // ------------------------------------------------------------
    // requests to the cpu
    // ------------------------------------------------------------
    always_comb begin
        irqRequest.group = pcFlags[3:0] & grpEnable[3:0]
                           & {NUM_GROUPS{globalEn}};
        if (senseMode == SENSE_LOW) begin
            irqRequest.ext0 = extMask[0] && globalEn && !extLevel;
        end else begin
            irqRequest.ext0 = extFlag[0] && extMask[0] && globalEn;
        end
    end

    // ------------------------------------------------------------
    // clockless wake path
    // ------------------------------------------------------------
    // compares raw pads with the last settled value, and takes line 0 in low-level
    // sense mode by its raw level, so that a change is seen with the clock stopped;
    // it is only a wake hint, flags still need the clock to run
    logic [NUM_PINS-1:0] wakePins;
    logic                wakeExt;
    logic [NUM_PINS-1:0] grpEnPins;

    always_comb begin
        grpEnPins = '0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            grpEnPins = grpEnPins | (GRP_PINS[g] & {NUM_PINS{grpEnable[g]}});
        end
    end

    assign wakePins = (change_watch_pins ^ stable[NUM_PINS-1:0])
                      & pinEnable & grpEnPins;
    assign wakeExt  = extMask[0] && ((senseMode == SENSE_LOW) ? !ext_irq0_pin
                      : (ext_irq0_pin ^ stable[NUM_PINS]));
    assign wakeRequest = (|wakePins) || wakeExt;

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic [7:0] rdIdx;
    logic       rdOk;
    logic [7:0] rdValue;

    assign s_axi_arready = !s_axi_rvalid;
    assign rdIdx = addrIndex(s_axi_araddr);
    assign rdOk  = addrInRange(s_axi_araddr) && isMapped(rdIdx);

    always_comb begin
        case (rdIdx)
            IDX_PC_FLAGS: rdValue = pcFlags;
            IDX_EXT_FLAG: rdValue = extFlag;
            IDX_EXT_MASK: rdValue = extMask;
            IDX_STATUS:   rdValue = statusReg;
            IDX_GRP_EN:   rdValue = grpEnable;
            IDX_SENSE:    rdValue = senseCtrl;
            IDX_MASK0:    rdValue = mask0;
            IDX_MASK1:    rdValue = mask1;
            IDX_MASK2:    rdValue = mask2;
            IDX_MASK3:    rdValue = mask3;
            default:      rdValue = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rdOk ? rdValue : 8'h00};
            s_axi_rresp  <= rdOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

/* eapc_irq_asserts.sv */
`timescale 1ns/1ps
module eapc_irq_asserts
    import eapc_pkg::*;
(
    input wire logic                core_clk,
    input wire logic                rstn,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic [1:0]          s_axi_rresp,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire logic                ext_irq0_pin,
    input wire logic [NUM_PINS-1:0] change_watch_pins,
    input wire eapc_irq_t           vectorTaken,
    input wire eapc_irq_t           irqRequest
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // --------------------------------------------------------
    // pad quiet time
    // --------------------------------------------------------
    // a pad event lands three edges after sampling, so six quiet cycles rule it out
    logic [28:0] prevPads;
    logic [3:0]  quietCnt;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) prevPads <= '0;
        else prevPads <= {ext_irq0_pin, change_watch_pins};
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) quietCnt <= 4'h0;
        else if ({ext_irq0_pin, change_watch_pins} != prevPads) quietCnt <= 4'h0;
        else if (quietCnt != 4'hF) quietCnt <= quietCnt + 4'h1;
    end

    sequence readTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence padsQuiet;
        quietCnt >= 4'h6;
    endsequence

    // --------------------------------------------------------
    // checks
    // --------------------------------------------------------
    chk_read_answer: assert property (readTaken |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer not held");
    chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data above low byte");
    chk_vector_clear: assert property (padsQuiet ##0 vectorTaken.group[0] |=>
        !irqRequest.group[0])
        else $error("group flag kept after vector");
    chk_request_cause: assert property ($rose(irqRequest.group[0]) |->
        $rose(s_axi_bvalid) || quietCnt < 4'h6)
        else $error("group request without cause");
    chk_reset_quiet: assert property (disable iff (1'b0) !rstn |->
        irqRequest == '0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active in reset");
endmodule

bind eapc_ext_pin_irq eapc_irq_asserts chk (
    .core_clk(core_clk), .rstn(rstn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ext_irq0_pin(ext_irq0_pin), .change_watch_pins(change_watch_pins),
    .vectorTaken(vectorTaken), .irqRequest(irqRequest)
);

/* eapc_pad_model.sv */
`timescale 1ns/1ps
module eapc_pad_model (
    input  wire logic core_clk,
    output logic      extPin,
    output logic [27:0] watchPins
);
    initial begin
        extPin = 1'b0;
        watchPins = '0;
    end

    // pads are driven whether the port is input or output, the way software provokes an irq
    // held eight cycles: shorter pulses may be lost by the synchroniser
    task automatic drive(input logic e, input logic [27:0] p);
        @(posedge core_clk);
        extPin <= e;
        watchPins <= p;
        repeat (8) @(posedge core_clk);
    endtask
endmodule

/* eapc_pkg.sv */
package eapc_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int         IDX_W        = 8;
    localparam logic [7:0] IDX_PC_FLAGS = 8'h3B;
    localparam logic [7:0] IDX_EXT_FLAG = 8'h3C;
    localparam logic [7:0] IDX_EXT_MASK = 8'h3D;
    localparam logic [7:0] IDX_STATUS   = 8'h3F;
    localparam logic [7:0] IDX_GRP_EN   = 8'h68;
    localparam logic [7:0] IDX_SENSE    = 8'h69;
    localparam logic [7:0] IDX_MASK0    = 8'h6B;
    localparam logic [7:0] IDX_MASK1    = 8'h6C;
    localparam logic [7:0] IDX_MASK2    = 8'h6D;
    localparam logic [7:0] IDX_MASK3    = 8'h73;

    // ------------------------------------------------------------
    // implemented bits and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [7:0] WM_PC_FLAGS  = 8'h0F;
    localparam logic [7:0] WM_EXT       = 8'h01;
    localparam logic [7:0] WM_STATUS    = 8'h80;
    localparam logic [7:0] WM_GRP_EN    = 8'h0F;
    localparam logic [7:0] WM_SENSE     = 8'h03;
    localparam logic [7:0] WM_MASK0     = 8'h0F;
    localparam logic [7:0] WM_MASK1     = 8'h08;
    localparam logic [7:0] WM_MASK2     = 8'hF7;
    localparam logic [7:0] WM_MASK3     = 8'h0F;
    localparam int         GIE_BIT      = 7;

    // ------------------------------------------------------------
    // pins and groups
    // ------------------------------------------------------------
    localparam int NUM_PINS   = 28;
    localparam int NUM_GROUPS = 4;
    localparam logic [27:0] GRP_PINS [NUM_GROUPS] = '{
        28'h000_000F,
        28'h000_0F00,
        28'h0FF_0000,
        28'hF00_0000
    };

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SENSE_LOW  = 2'h0,
        SENSE_ANY  = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } eapc_sense_t;

    // one bit per vector: external line 0 and the four groups
    typedef struct packed {
        logic [3:0] group;
        logic       ext0;
    } eapc_irq_t;

endpackage

/* tb.sv */
`timescale 1ns/1ps
module tb;
    import eapc_pkg::*;

    logic        core_clk    = 1'b0;
    logic        rstn        = 1'b1;
    logic [11:0] awAddr      = '0;
    logic        awValid     = 1'b0;
    logic [31:0] wData       = '0;
    logic        wValid      = 1'b0;
    logic        bReady      = 1'b0;
    logic [11:0] arAddr      = '0;
    logic        arValid     = 1'b0;
    logic        rReady      = 1'b0;
    logic        sleepActive = 1'b0;
    eapc_irq_t   vectorTaken = '0;
    logic        awReady, wReady, bValid, arReady, rValid, wakeRequest, extPin;
    logic [1:0]  bResp, rResp;
    logic [31:0] rData;
    logic [27:0] watchPins;
    eapc_irq_t   irqRequest;
    int          fails = 0;
    int          checks = 0;
    int          lag = 0;
    logic [7:0]  rwIdx [6] = '{IDX_EXT_MASK, IDX_GRP_EN, IDX_MASK0, IDX_MASK1, IDX_MASK2, IDX_MASK3};
    logic [7:0]  rwMask [6] = '{8'h01, 8'h0F, 8'h0F, 8'h08, 8'hF7, 8'h0F};
    logic [7:0]  grpMask [4] = '{IDX_MASK0, IDX_MASK1, IDX_MASK2, IDX_MASK3};
    logic [7:0]  pinBit [4] = '{8'h01, 8'h08, 8'h01, 8'h01};
    int          pinOf [4] = '{0, 11, 16, 24};

    always #5 core_clk = ~core_clk;

    eapc_ext_pin_irq #(.ADDR_W(12)) dut (
        .core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .ext_irq0_pin(extPin), .change_watch_pins(watchPins), .sleepActive(sleepActive),
        .vectorTaken(vectorTaken), .irqRequest(irqRequest), .wakeRequest(wakeRequest)
    );

    eapc_pad_model pad (.core_clk(core_clk), .extPin(extPin), .watchPins(watchPins));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge core_clk);
        awAddr <= {2'b00, idx, 2'b00};
        wData <= {24'h00_0000, d};
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= (lag == 0);
        while (aw || w) begin
            @(posedge core_clk);
            if (aw && awReady) begin
                awValid <= 1'b0;
                aw = 1'b0;
            end
            if (w && wReady) begin
                wValid <= 1'b0;
                w = 1'b0;
            end
        end
        // a late bready keeps the answer standing for a few cycles
        repeat (lag) @(posedge core_clk);
        bReady <= 1'b1;
        do @(posedge core_clk); while (!bValid);
        check("bresp", 32'(bResp), 32'(resp));
        bReady <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] resp);
        @(posedge core_clk);
        arAddr <= {2'b00, idx, 2'b00};
        arValid <= 1'b1;
        rReady <= (lag == 0);
        do @(posedge core_clk); while (!arReady);
        arValid <= 1'b0;
        repeat (lag) @(posedge core_clk);
        rReady <= 1'b1;
        do @(posedge core_clk); while (!rValid);
        check("rdata", rData, {24'h00_0000, exp});
        check("rresp", 32'(rResp), 32'(resp));
        rReady <= 1'b0;
    endtask

    task automatic take(input eapc_irq_t v);
        @(posedge core_clk);
        vectorTaken <= v;
        @(posedge core_clk);
        vectorTaken <= '0;
    endtask

    task automatic close_out;
        if (fails == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        close_out();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rstn <= 1'b0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(IDX_PC_FLAGS, 8'h00, RESP_OKAY);
        rd(IDX_EXT_FLAG, 8'h00, RESP_OKAY);
        wr(IDX_PC_FLAGS, 8'hFF, RESP_OKAY);
        rd(IDX_PC_FLAGS, 8'h00, RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            rd(rwIdx[i], 8'h00, RESP_OKAY);
            wr(rwIdx[i], 8'hFF, RESP_OKAY);
            rd(rwIdx[i], rwMask[i], RESP_OKAY);
            wr(rwIdx[i], 8'h00, RESP_OKAY);
        end
        lag = 3;
        wr(8'h50, 8'hFF, RESP_SLVERR);
        rd(8'h50, 8'h00, RESP_SLVERR);
        lag = 0;
        // each group: a masked change is ignored, an unmasked one raises the flag
        wr(IDX_STATUS, 8'h80, RESP_OKAY);
        for (int g = 0; g < 4; g++) begin
            wr(IDX_GRP_EN, 8'h01 << g, RESP_OKAY);
            pad.drive(1'b0, 28'h000_0001 << pinOf[g]);
            rd(IDX_PC_FLAGS, 8'h00, RESP_OKAY);
            wr(grpMask[g], pinBit[g], RESP_OKAY);
            pad.drive(1'b0, '0);
            rd(IDX_PC_FLAGS, 8'h01 << g, RESP_OKAY);
            check("irqGroup", 32'(irqRequest.group), 32'h1 << g);
            wr(IDX_PC_FLAGS, 8'h00, RESP_OKAY);
            rd(IDX_PC_FLAGS, 8'h01 << g, RESP_OKAY);
            if (g % 2 == 0) take('{group: 4'h1 << g, ext0: 1'b0});
            else wr(IDX_PC_FLAGS, 8'h01 << g, RESP_OKAY);
            rd(IDX_PC_FLAGS, 8'h00, RESP_OKAY);
            wr(grpMask[g], 8'h00, RESP_OKAY);
        end
        // pin 19 has no mask bit; a flag without global enable gives no request
        wr(IDX_MASK2, 8'hFF, RESP_OKAY);
        wr(IDX_GRP_EN, 8'h04, RESP_OKAY);
        wr(IDX_STATUS, 8'h00, RESP_OKAY);
        pad.drive(1'b0, 28'h008_0000);
        rd(IDX_PC_FLAGS, 8'h00, RESP_OKAY);
        pad.drive(1'b0, 28'h048_0000);
        rd(IDX_PC_FLAGS, 8'h04, RESP_OKAY);
        check("irqGroup", 32'(irqRequest.group), 32'h0);
        wr(IDX_STATUS, 8'h80, RESP_OKAY);
        check("irqGroup", 32'(irqRequest.group), 32'h4);
        wr(IDX_PC_FLAGS, 8'h04, RESP_OKAY);
        check("irqGroup", 32'(irqRequest.group), 32'h0);
        // external line: low level first, then each edge mode
        wr(IDX_EXT_MASK, 8'h01, RESP_OKAY);
        check("irqExt", 32'(irqRequest.ext0), 32'h1);
        check("wake", 32'(wakeRequest), 32'h1);
        rd(IDX_EXT_FLAG, 8'h00, RESP_OKAY);
        pad.drive(1'b1, '0);
        check("irqExt", 32'(irqRequest.ext0), 32'h0);
        check("wake", 32'(wakeRequest), 32'h0);
        for (int m = 1; m < 4; m++) begin
            wr(IDX_SENSE, 8'(m), RESP_OKAY);
            wr(IDX_EXT_FLAG, 8'h01, RESP_OKAY);
            pad.drive(1'b0, '0);
            rd(IDX_EXT_FLAG, {7'h00, m != 3}, RESP_OKAY);
            check("irqExt", 32'(irqRequest.ext0), 32'(m != 3));
            wr(IDX_EXT_FLAG, 8'h01, RESP_OKAY);
            pad.drive(1'b1, '0);
            rd(IDX_EXT_FLAG, {7'h00, m != 2}, RESP_OKAY);
            wr(IDX_EXT_FLAG, 8'h01, RESP_OKAY);
        end
        // sleeping with the line masked gates its input, which reads as a fall
        wr(IDX_SENSE, 8'h02, RESP_OKAY);
        wr(IDX_EXT_FLAG, 8'h01, RESP_OKAY);
        wr(IDX_EXT_MASK, 8'h00, RESP_OKAY);
        @(posedge core_clk);
        sleepActive <= 1'b1;
        repeat (8) @(posedge core_clk);
        rd(IDX_EXT_FLAG, 8'h01, RESP_OKAY);
        check("irqExt", 32'(irqRequest.ext0), 32'h0);
        sleepActive <= 1'b0;
        wr(IDX_EXT_MASK, 8'h01, RESP_OKAY);
        check("irqExt", 32'(irqRequest.ext0), 32'h1);
        take('{group: 4'h0, ext0: 1'b1});
        rd(IDX_EXT_FLAG, 8'h00, RESP_OKAY);
        close_out();
    end
endmodule
